// ---- rtl/mie_top.sv ----
// Interrupt enable and flag logic: control, peripheral enables and flags,
// request to the core. Assumes event pulses on i_core_clk, async pins.
`include "mie_map.svh"
`default_nettype none
module mie_top #(
  parameter int PINS = 8
) (
  input  wire logic            i_core_clk,
  input  wire logic            i_srst,
  input  wire logic [3:0]      i_addr,
  input  wire logic [7:0]      i_wdata,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  output logic      [7:0]      o_rdata,
  input  wire logic            i_timer_zero_ovf,
  input  wire logic            i_ext_pin,
  input  wire logic [PINS-1:0] i_change_pins,
  input  wire logic [7:0]      i_per_set_one,
  input  wire logic [7:0]      i_per_set_two,
  input  wire logic            i_accept,
  input  wire logic            i_return_from_irq_instr,
  output logic                 o_irq_req,
  output logic      [15:0]     o_vector
);
  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  mie_pkg::mie_bus_t  bus;
  mie_pkg::mie_core_t core;
  logic [4:0]      ctrl_reg;
  logic [4:0]      ctrl_next;
  logic [7:0]      en_one_reg;
  logic [7:0]      en_one_next;
  logic [7:0]      en_two_reg;
  logic [7:0]      en_two_next;
  logic            edge_sel_reg;
  logic            edge_sel_next;
  logic            t0_flag_reg;
  logic            t0_flag_next;
  logic            ext_flag_reg;
  logic            ext_flag_next;
  logic            ext_prev_reg;
  logic [PINS-1:0] pin_prev_reg;
  logic [7:0]      rdata_reg;
  logic [7:0]      rdata_next;
  logic            ext_sync;
  logic [PINS-1:0] pins_sync;
  logic [7:0]      req_one;
  logic [7:0]      req_two;
  logic [PINS-1:0] pin_flags;
  logic            ext_edge;
  logic            pc_summary;
  logic            core_pair;
  logic            per_pair;
  logic [7:0]      core_view;

  assign bus  = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign core = '{accept: i_accept, ret: i_return_from_irq_instr};

  // Write decode used by every register
  function automatic logic hit(input mie_pkg::mie_bus_t b, input logic [3:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction : hit

  // ----------------------------------------------------------------------
  // Pin synchronisers and flag banks
  // ----------------------------------------------------------------------
  mie_sync #(.W(1)) u_ext_sync (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_async    (i_ext_pin),
    .o_sync     (ext_sync)
  );

  mie_sync #(.W(PINS)) u_pin_sync (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_async    (i_change_pins),
    .o_sync     (pins_sync)
  );

  // Peripheral flags share bit positions with their enables
  mie_flags #(.W(8)) u_req_one (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_set      (i_per_set_one),
    .i_wr       (hit(bus, `MIE_OFS_PER_REQ_ONE)),
    .i_wdata    (bus.wdata),
    .o_flags    (req_one)
  );

  mie_flags #(.W(8)) u_req_two (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_set      (i_per_set_two & `MIE_EN_TWO_MASK),
    .i_wr       (hit(bus, `MIE_OFS_PER_REQ_TWO)),
    .i_wdata    (bus.wdata & `MIE_EN_TWO_MASK),
    .o_flags    (req_two)
  );

  // Per-pin change flags: any transition sets, software writes zero to clear
  mie_flags #(.W(PINS)) u_pin_flags (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_set      (pins_sync ^ pin_prev_reg),
    .i_wr       (hit(bus, `MIE_OFS_PIN_CHANGE)),
    .i_wdata    (bus.wdata[PINS-1:0]),
    .o_flags    (pin_flags)
  );

  // ----------------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------------
  assign ext_edge = edge_sel_reg ? (ext_sync && !ext_prev_reg)
                                 : (!ext_sync && ext_prev_reg);
  assign pc_summary = |pin_flags;

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      ext_prev_reg <= 1'b0;
      pin_prev_reg <= '0;
    end
    else
    begin
      ext_prev_reg <= ext_sync;
      pin_prev_reg <= pins_sync;
    end
  end

  // ----------------------------------------------------------------------
  // Control and enable registers
  // ----------------------------------------------------------------------
  // ctrl_reg holds bits 7..3 of the core control register
  always_comb
  begin
    ctrl_next     = ctrl_reg;
    en_one_next   = en_one_reg;
    en_two_next   = en_two_reg;
    edge_sel_next = edge_sel_reg;
    t0_flag_next  = t0_flag_reg;
    ext_flag_next = ext_flag_reg;
    if (hit(bus, `MIE_OFS_CORE_CTRL))
    begin
      ctrl_next     = bus.wdata[7:3];
      t0_flag_next  = bus.wdata[`MIE_BIT_T0IF];
      ext_flag_next = bus.wdata[`MIE_BIT_EXTIF];
    end
    if (hit(bus, `MIE_OFS_PER_EN_ONE))
      en_one_next = bus.wdata;
    if (hit(bus, `MIE_OFS_PER_EN_TWO))
      en_two_next = bus.wdata & `MIE_EN_TWO_MASK;
    if (hit(bus, `MIE_OFS_OPTION))
      edge_sel_next = bus.wdata[`MIE_BIT_EDGE_SEL];
    // Core accepting a request drops global enable, return restores it
    if (core.accept)
      ctrl_next[4] = 1'b0;
    else if (core.ret)
      ctrl_next[4] = 1'b1;
    // Events win over a software clear in the same cycle
    if (i_timer_zero_ovf)
      t0_flag_next = 1'b1;
    if (ext_edge)
      ext_flag_next = 1'b1;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      ctrl_reg     <= 5'h00;
      en_one_reg   <= `MIE_RESET_VAL;
      en_two_reg   <= `MIE_RESET_VAL;
      edge_sel_reg <= 1'b0;
      t0_flag_reg  <= 1'b0;
      ext_flag_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg     <= ctrl_next;
      en_one_reg   <= en_one_next;
      en_two_reg   <= en_two_next;
      edge_sel_reg <= edge_sel_next;
      t0_flag_reg  <= t0_flag_next;
      ext_flag_reg <= ext_flag_next;
    end
  end

  // ----------------------------------------------------------------------
  // Request to the core
  // ----------------------------------------------------------------------
  assign core_view = {ctrl_reg, t0_flag_reg, ext_flag_reg, pc_summary};
  // Software should clear a flag first, or a stale one requests at once
  assign core_pair = (core_view[`MIE_BIT_T0IE] && t0_flag_reg)
                   || (core_view[`MIE_BIT_EXTIE] && ext_flag_reg)
                   || (core_view[`MIE_BIT_PCIE] && pc_summary);
  assign per_pair  = core_view[`MIE_BIT_PERIPHERAL_GROUP_ENABLE]
                   && (|(en_one_reg & req_one) || |(en_two_reg & req_two));
  assign o_irq_req = core_view[`MIE_BIT_GIE] && (core_pair || per_pair);
  assign o_vector  = `MIE_VECTOR;

  // ----------------------------------------------------------------------
  // Read port: data valid the cycle after the strobe
  // ----------------------------------------------------------------------
  always_comb
  begin
    rdata_next = 8'h00;
    if (bus.rd)
    begin
      unique case (bus.addr)
        `MIE_OFS_CORE_CTRL:   rdata_next = core_view;
        `MIE_OFS_PER_EN_ONE:  rdata_next = en_one_reg;
        `MIE_OFS_PER_EN_TWO:  rdata_next = en_two_reg;
        `MIE_OFS_PER_REQ_ONE: rdata_next = req_one;
        `MIE_OFS_PER_REQ_TWO: rdata_next = req_two;
        `MIE_OFS_PIN_CHANGE:  rdata_next = 8'(pin_flags);
        `MIE_OFS_OPTION:      rdata_next = {7'h00, edge_sel_reg};
        default:              rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  assign o_rdata = rdata_reg;
endmodule : mie_top
`default_nettype wire

// ---- rtl/mie_map.svh ----
// Register offsets, field positions, reset values and the vector address of the
// interrupt enable block. Assumes inclusion by bare name from rtl/.
// Notes on behaviour
// - Global enable gates every interrupt request.
// - Peripheral group enable gates peripheral requests.
// - Peripheral sources also need the group enable.
// - Flags set regardless of any enable.
// - Timer-zero enable gates the overflow flag.
// - External pin enable gates the pin flag.
// - Pin-change enable gates the summary flag.
// - Timer-zero flag sets on counter overflow.
// - External pin flag sets on qualifying edge.
// - Summary flag is OR of per-pin flags.
// - Summary flag read-only; clears with per-pin flags.
// - Enable one holds eight peripheral enables.
// - Enable two holds seven peripheral enables.
// - Enable two bit four reads zero.
// - All implemented bits reset to zero.
// - Acceptance clears global enable, vectors core.
// - Return instruction sets global enable again.
// - Edge select picks rising or falling edge.
// - Request flags mirror enable bit positions.
`ifndef MIE_MAP_SVH
`define MIE_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define MIE_OFS_CORE_CTRL   4'h0
`define MIE_OFS_PER_EN_ONE  4'h1
`define MIE_OFS_PER_EN_TWO  4'h2
`define MIE_OFS_PER_REQ_ONE 4'h3
`define MIE_OFS_PER_REQ_TWO 4'h4
`define MIE_OFS_PIN_CHANGE  4'h5
`define MIE_OFS_OPTION      4'h6

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define MIE_BIT_GIE         3'd7
`define MIE_BIT_PERIPHERAL_GROUP_ENABLE        3'd6
`define MIE_BIT_T0IE        3'd5
`define MIE_BIT_EXTIE       3'd4
`define MIE_BIT_PCIE        3'd3
`define MIE_BIT_T0IF        3'd2
`define MIE_BIT_EXTIF       3'd1
`define MIE_BIT_PCIF        3'd0
`define MIE_BIT_EDGE_SEL    3'd0
`define MIE_EN_TWO_MASK     8'hEF
`define MIE_RESET_VAL       8'h00
`define MIE_VECTOR          16'h0004

`endif

// ---- rtl/mie_pkg.sv ----
// Types shared by the interrupt enable block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package mie_pkg;
  // Register access from software
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mie_bus_t;

  // Core sequencer handshake
  typedef struct packed {
    logic accept;
    logic ret;
  } mie_core_t;
endpackage : mie_pkg
`default_nettype wire

// ---- rtl/mie_sync.sv ----
// Two flip-flop synchroniser for pin levels.
// Assumes the input is asynchronous to i_core_clk.
`default_nettype none
module mie_sync #(
  parameter int W = 1
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  // First stage feeds only the second
  always_comb
  begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;
endmodule : mie_sync
`default_nettype wire

// ---- rtl/mie_flags.sv ----
// Bank of sticky flags: a set pulse beats a software clear.
// Assumes set pulses are on i_core_clk.
`default_nettype none
module mie_flags #(
  parameter int W = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_set,
  input  wire logic         i_wr,
  input  wire logic [W-1:0] i_wdata,
  output logic      [W-1:0] o_flags
);
  logic [W-1:0] flags_reg;
  logic [W-1:0] flags_next;

  // Set wins over clear so no event is lost
  always_comb
  begin
    flags_next = flags_reg;
    if (i_wr)
      flags_next = i_wdata;
    flags_next = flags_next | i_set;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      flags_reg <= '0;
    else
      flags_reg <= flags_next;
  end

  assign o_flags = flags_reg;
endmodule : mie_flags
`default_nettype wire

// ---- verif/mie_top_chk.sv ----
// Port checker for the interrupt enable block.
// Assumes it is bound onto mie_top and sees one clock domain.
`default_nettype none
module mie_top_chk #(
  parameter int PINS = 8
) (
  input  wire logic            i_core_clk,
  input  wire logic            i_srst,
  input  wire logic [3:0]      i_addr,
  input  wire logic [7:0]      i_wdata,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  input  wire logic [7:0]      o_rdata,
  input  wire logic            i_timer_zero_ovf,
  input  wire logic            i_ext_pin,
  input  wire logic [PINS-1:0] i_change_pins,
  input  wire logic [7:0]      i_per_set_one,
  input  wire logic [7:0]      i_per_set_two,
  input  wire logic            i_accept,
  input  wire logic            i_return_from_irq_instr,
  input  wire logic            o_irq_req,
  input  wire logic [15:0]     o_vector
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  // Control write with no core handshake beside it, so priority is moot
  sequence s_ctrl_wr;
    i_wr && i_addr == 4'h0 && !i_accept && !i_return_from_irq_instr;
  endsequence

  vector_fixed_a: assert property (o_vector == 16'h0004)
    else $error("vector moved");
  reset_clear_a: assert property ($fell(i_srst) |-> !o_irq_req && o_rdata == 8'h00)
    else $error("state not cleared by reset");
  accept_mask_a: assert property (i_accept && !i_wr |=> !o_irq_req)
    else $error("request stands after accept");
  global_off_a: assert property (s_ctrl_wr ##0 !i_wdata[7] |=> !o_irq_req)
    else $error("request with global enable clear");
  group_off_a: assert property (s_ctrl_wr ##0 i_wdata[6:3] == 4'h0 |=> !o_irq_req)
    else $error("request with all enables clear");
  timer_path_a: assert property (s_ctrl_wr ##0 (i_wdata & 8'hA4) == 8'hA4 |=> o_irq_req)
    else $error("timer pair gives no request");
  pin_path_a: assert property (s_ctrl_wr ##0 (i_wdata & 8'h92) == 8'h92 |=> o_irq_req)
    else $error("pin pair gives no request");
  hole_zero_a: assert property (i_rd && i_addr == 4'h2 |=> !o_rdata[4])
    else $error("reserved bit reads one");
  unmapped_zero_a: assert property (i_rd && i_addr > 4'h6 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : mie_top_chk
`default_nettype wire

// ---- verif/mie_core_model.sv ----
// Model of the core sequencer and of the peripheral event sources.
// Assumes the bench calls its tasks; it drives just after rising edges.
`default_nettype none
module mie_core_model (
  input  wire logic          i_core_clk,
  input  wire logic          i_irq_req,
  output logic               o_tmr_ovf,
  output logic               o_ext_pin,
  output logic [7:0]         o_pins,
  output logic [7:0]         o_set_one,
  output logic [7:0]         o_set_two,
  output mie_pkg::mie_core_t o_core
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Sources
  // ------------------------------------------------------------------
  initial {o_tmr_ovf, o_ext_pin, o_pins, o_set_one, o_set_two, o_core} = '0;

  // One-cycle event pulses from the timers and peripherals
  task automatic events(input logic t, input logic [7:0] a, input logic [7:0] b);
    @(posedge i_core_clk);
    o_tmr_ovf <= t;
    o_set_one <= a;
    o_set_two <= b;
    @(posedge i_core_clk);
    {o_tmr_ovf, o_set_one, o_set_two} <= '0;
  endtask : events

  // Pins hold; five cycles covers the synchroniser and edge stage
  task automatic pins(input logic e, input logic [7:0] p);
    @(posedge i_core_clk);
    o_ext_pin <= e;
    o_pins <= p;
    repeat (5) @(posedge i_core_clk);
  endtask : pins

  // Core takes a pending request after lat+1 cycles; a slow core waits longer
  task automatic take(input int lat);
    int n = 0;
    while (i_irq_req !== 1'b1 && n < 20)
    begin
      @(posedge i_core_clk);
      n++;
    end
    repeat (lat + 1) @(posedge i_core_clk);
    o_core.accept <= 1'b1;
    @(posedge i_core_clk);
    o_core.accept <= 1'b0;
  endtask : take

  // Return instruction retired by the core
  task automatic leave();
    @(posedge i_core_clk);
    o_core.ret <= 1'b1;
    @(posedge i_core_clk);
    o_core.ret <= 1'b0;
  endtask : leave
endmodule : mie_core_model
`default_nettype wire

// ---- verif/mie_top_bench.sv ----
// Self-checking bench for the interrupt enable block.
// Assumes the design files and the core model are compiled first.
`default_nettype none
module mie_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Harness
  // ------------------------------------------------------------------
  logic i_core_clk = 1'b0, i_srst, i_wr, i_rd, i_timer_zero_ovf, i_ext_pin, o_irq_req;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata, i_change_pins, i_per_set_one, i_per_set_two;
  logic [15:0] o_vector;
  logic        i_accept, i_return_from_irq_instr;
  mie_pkg::mie_core_t core;
  int num_errors = 0;
  int samples_checked = 0;

  assign i_accept = core.accept;
  assign i_return_from_irq_instr = core.ret;
  always #12.5 i_core_clk = ~i_core_clk;

  mie_top #(.PINS(8)) u_dut (.*);
  mie_core_model u_part (.i_core_clk(i_core_clk), .i_irq_req(o_irq_req),
    .o_tmr_ovf(i_timer_zero_ovf), .o_ext_pin(i_ext_pin), .o_pins(i_change_pins),
    .o_set_one(i_per_set_one), .o_set_two(i_per_set_two), .o_core(core));

  // Register bus cycles and compares
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    samples_checked++;
    if (o_rdata !== e)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, o_rdata, e);
    end
  endtask : rd_chk

  task automatic req_chk(input logic e);
    samples_checked++;
    if (o_irq_req !== e)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, o_irq_req, e);
    end
  endtask : req_chk

  task automatic tally_and_finish();
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // Hang guard, ample for the roughly 160 cycles the tests take
  initial
  begin
    repeat (3000) @(posedge i_core_clk);
    num_errors++;
    tally_and_finish();
  end

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial
  begin
    {i_srst, i_addr, i_wdata, i_wr, i_rd} = {1'b1, 14'h0};
    repeat (6) @(posedge i_core_clk);
    i_srst <= 1'b0;
    for (int k = 0; k < 8; k++) rd_chk(k == 7 ? 4'hF : 4'(k), 8'h00);
    wr(4'h1, 8'hFF);
    rd_chk(4'h1, 8'hFF);
    wr(4'h2, 8'hFF);
    rd_chk(4'h2, 8'hEF);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h0, 8'hFF);
    rd_chk(4'h0, 8'hFE);
    req_chk(1'b1);
    wr(4'h0, 8'h00);
    req_chk(1'b0);
    u_part.events(1'b1, 8'h00, 8'h00);
    rd_chk(4'h0, 8'h04);
    req_chk(1'b0);
    wr(4'h0, 8'hA4);
    req_chk(1'b1);
    wr(4'h0, 8'h84);
    req_chk(1'b0);
    wr(4'h0, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h80);
    u_part.events(1'b0, 8'h01, 8'h00);
    rd_chk(4'h3, 8'h01);
    req_chk(1'b0);
    wr(4'h0, 8'hC0);
    req_chk(1'b1);
    u_part.take(2);
    #1;
    req_chk(1'b0);
    rd_chk(4'h0, 8'h40);
    u_part.leave();
    rd_chk(4'h0, 8'hC0);
    req_chk(1'b1);
    u_part.events(1'b0, 8'h00, 8'hFF);
    rd_chk(4'h4, 8'hEF);
    wr(4'h2, 8'h08);
    wr(4'h1, 8'h00);
    wr(4'h3, 8'h00);
    req_chk(1'b1);
    wr(4'h2, 8'h00);
    req_chk(1'b0);
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h00);
    wr(4'h6, 8'h01);
    u_part.pins(1'b1, 8'h00);
    rd_chk(4'h0, 8'h02);
    wr(4'h0, 8'h00);
    u_part.pins(1'b0, 8'h00);
    rd_chk(4'h0, 8'h00);
    wr(4'h6, 8'h00);
    u_part.pins(1'b1, 8'h00);
    rd_chk(4'h0, 8'h00);
    u_part.pins(1'b0, 8'h00);
    rd_chk(4'h0, 8'h02);
    wr(4'h0, 8'h08);
    u_part.pins(1'b0, 8'h01);
    rd_chk(4'h5, 8'h01);
    rd_chk(4'h0, 8'h09);
    wr(4'h0, 8'h88);
    req_chk(1'b1);
    wr(4'h5, 8'h00);
    rd_chk(4'h0, 8'h88);
    req_chk(1'b0);
    u_part.pins(1'b0, 8'h00);
    @(posedge i_core_clk);
    i_srst <= 1'b1;
    @(posedge i_core_clk);
    i_srst <= 1'b0;
    rd_chk(4'h0, 8'h00);
    req_chk(1'b0);
    tally_and_finish();
  end
endmodule : mie_top_bench

bind mie_top mie_top_chk #(.PINS(PINS)) u_chk (.*);
`default_nettype wire
